// ==== hdl/sbcra_top.sv ====
`timescale 1ns/1ps
`include "sbcra_consts.svh"

module sbcra_top #(
    parameter int CNT_W = 6
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire sbcra_pkg::sbcra_spi_t  spi_in,
    output logic                        miso,
    output logic                        miso_oe,
    input  wire sbcra_pkg::sbcra_stat_t hw_stat,
    input  wire logic                   hw_mode_load,
    input  wire logic [1:0]             hw_mode,
    input  wire logic                   restart,
    output sbcra_pkg::sbcra_ctrl_t      ctrl,
    output logic                        soft_reset
);
    import sbcra_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************

    // The bit counter must hold a full long frame plus saturation.
    generate
        if (CNT_W != 6)
        begin : g_bad_cnt
            $error("sbcra_top: CNT_W must be 6");
        end
    endgenerate

    // ****************************************************************
    // Decoding functions
    // ****************************************************************

    localparam sbcra_stat_t STAT_MASK = `SBCRA_STAT_MASK;

    // True for every address that holds a register.
    function automatic logic is_valid(input logic [6:0] a);
        is_valid = (a == `SBCRA_A_MSC) || (a == `SBCRA_A_HC1) ||
                   (a == `SBCRA_A_HC2) || (a == `SBCRA_A_GPIO) ||
                   ((a >= `SBCRA_A_STAT) && (a < `SBCRA_A_STEND));
    endfunction : is_valid

    // Next register address above a, wrapping to the lowest one.
    function automatic logic [6:0] next_valid(input logic [6:0] a);
        logic [6:0] nv;
        nv = `SBCRA_A_MSC;
        for (int i = 127; i >= 0; i--)
        begin
            if ((7'(i) > a) && is_valid(7'(i)))
            begin
                nv = 7'(i);
            end
        end
        next_valid = nv;
    endfunction : next_valid

    // Read value of one register; reserved and unmapped bits give zero.
    function automatic sbcra_byte_t reg_rd(
        input logic [6:0]   a,
        input sbcra_state_t st,
        input sbcra_stat_t  hw
    );
        logic [3:0]  idx;
        sbcra_byte_t v;
        idx = 4'(a - `SBCRA_A_STAT);
        v   = 8'h00;
        case (a)
            `SBCRA_A_MSC:  v = st.ctrl.msc & ~`SBCRA_MSC_RSV;
            `SBCRA_A_HC1:  v = st.ctrl.hc1;
            `SBCRA_A_HC2:  v = st.ctrl.hc2;
            `SBCRA_A_GPIO: v = st.ctrl.gpio;
            default:
            begin
                if (is_valid(a) && (idx < 4'(`SBCRA_N_WC)))
                begin
                    v = st.wc[idx[2:0]] & STAT_MASK[idx];
                end
                else if (is_valid(a))
                begin
                    v = hw[idx] & STAT_MASK[idx];
                end
            end
        endcase
        reg_rd = v;
    endfunction : reg_rd

    // Apply one serial write to a copy of the state.
    function automatic sbcra_state_t reg_wr(
        input sbcra_state_t st,
        input logic [6:0]   a,
        input sbcra_byte_t  d
    );
        sbcra_state_t r;
        logic [3:0]   idx;
        sbcra_byte_t  lk;
        r   = st;
        idx = 4'(a - `SBCRA_A_STAT);
        lk  = `SBCRA_HC2_LKD | `SBCRA_HC2_LK1;
        case (a)
            `SBCRA_A_MSC:
            begin
                // Reserved bits are dropped even if the master breaks its side.
                r.ctrl.msc  = d & ~`SBCRA_MSC_RSV;
                r.srst_pend = (d[7:6] == `SBCRA_MODE_RST);
            end
            `SBCRA_A_HC1:
            begin
                if ((st.ctrl.hc1 & `SBCRA_HC1_LK0) != 8'h00)
                begin
                    r.ctrl.hc1 = (st.ctrl.hc1 & `SBCRA_HC1_LKD) |
                                 (d & ~`SBCRA_HC1_LKD);
                end
                else
                begin
                    r.ctrl.hc1 = d;
                end
            end
            `SBCRA_A_HC2:
            begin
                if ((st.ctrl.hc2 & `SBCRA_HC2_LK1) != 8'h00)
                begin
                    r.ctrl.hc2 = (st.ctrl.hc2 & lk) | (d & ~lk);
                end
                else
                begin
                    r.ctrl.hc2 = d;
                end
            end
            `SBCRA_A_GPIO:
            begin
                if ((st.ctrl.hc1 & `SBCRA_HC1_LK0) != 8'h00)
                begin
                    r.ctrl.gpio = (st.ctrl.gpio & `SBCRA_GPIO_LKD) |
                                  (d & ~`SBCRA_GPIO_LKD);
                end
                else
                begin
                    r.ctrl.gpio = d;
                end
            end
            default:
            begin
                // Any write access clears a clearable status register.
                if (is_valid(a) && (idx < 4'(`SBCRA_N_WC)))
                begin
                    r.wc[idx[2:0]] = `SBCRA_WC_CLR;
                end
            end
        endcase
        reg_wr = r;
    endfunction : reg_wr

    // ****************************************************************
    // State
    // ****************************************************************

    sbcra_state_t s;
    sbcra_state_t n;
    logic         sck_rise;
    logic         sck_fall;
    logic         cs_fall;
    logic         cs_rise;
    logic         active;
    logic         lock0;
    logic         lock1;
    logic [6:0]   addr;
    sbcra_byte_t  keep1;
    sbcra_byte_t  keep2;

    // Edges come from the second sync stage and its delayed copy only.
    assign sck_rise = s.sy2.sck & ~s.dly.sck;
    assign sck_fall = ~s.sy2.sck & s.dly.sck;
    assign cs_fall  = ~s.sy2.cs_n & s.dly.cs_n;
    assign cs_rise  = s.sy2.cs_n & ~s.dly.cs_n;
    assign active   = ~s.sy2.cs_n;
    assign lock0    = (s.ctrl.hc1 & `SBCRA_HC1_LK0) != 8'h00;
    assign lock1    = (s.ctrl.hc2 & `SBCRA_HC2_LK1) != 8'h00;
    assign addr     = s.rx[6:0];
    assign keep1    = lock0 ? (`SBCRA_HC1_LKD | `SBCRA_HC1_LK0) : 8'h00;
    assign keep2    = lock1 ? (`SBCRA_HC2_LKD | `SBCRA_HC2_LK1) : 8'h00;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Frame engine, register writes, then the reset and status overlays.
    always_comb
    begin
        n           = s;
        n.sy1       = spi_in;
        n.sy2       = s.sy1;
        n.dly       = s.sy2;
        n.srst_pend = 1'b0;
        n.srst_out  = s.srst_pend;
        // Frame start: the fault byte goes out first, bit 0 at once.
        if (cs_fall)
        begin
            n.cnt  = 6'h00;
            n.rx   = 32'h0000_0000;
            n.oe   = 1'b1;
            n.miso = s.wc[`SBCRA_IDX_FAULT][0];
            n.sh   = {9'h000, s.wc[`SBCRA_IDX_FAULT][7:1]};
        end
        else if (active && sck_rise && (s.cnt != `SBCRA_CNT_MAX))
        begin
            // Bits arrive LSB first, each at its own frame position.
            if (!s.cnt[5])
            begin
                n.rx[s.cnt[4:0]] = s.sy2.mosi;
            end
            n.cnt = s.cnt + 6'h01;
            // Address is complete; the read bytes follow from bit 8 on.
            if (s.cnt == `SBCRA_CNT_ADDR)
            begin
                n.sh = {reg_rd(next_valid(addr), s, hw_stat),
                        reg_rd(addr, s, hw_stat)};
            end
        end
        else if (active && sck_fall)
        begin
            n.miso = s.sh[0];
            n.sh   = {1'b0, s.sh[15:1]};
        end
        // Frame end: only exact 16- or 32-bit write frames take effect.
        if (cs_rise)
        begin
            n.oe   = 1'b0;
            n.miso = 1'b0;
            if (s.rx[`SBCRA_RW_BIT])
            begin
                if (s.cnt == `SBCRA_BITS_SHORT)
                begin
                    n = reg_wr(n, addr, s.rx[15:8]);
                end
                else if (s.cnt == `SBCRA_BITS_LONG)
                begin
                    n = reg_wr(n, addr, s.rx[15:8]);
                    n = reg_wr(n, next_valid(addr), s.rx[23:16]);
                end
            end
        end
        // The mode field and, on restart, msc bits 7:2 are the control bits the chip may move.
        if (hw_mode_load)
        begin
            n.ctrl.msc[7:6] = hw_mode;
        end
        // Restart touches only the mode register; its low bits are kept.
        if (restart)
        begin
            n.ctrl.msc = (s.ctrl.msc & `SBCRA_MSC_KEEP) |
                         (`SBCRA_MSC_POR & ~`SBCRA_MSC_KEEP);
        end
        // Soft reset wins over a write in the same cycle.
        if (s.srst_pend)
        begin
            n.ctrl.msc  = `SBCRA_MSC_POR;
            n.ctrl.hc1  = (s.ctrl.hc1 & keep1) |
                          (`SBCRA_HC1_POR & ~keep1);
            n.ctrl.hc2  = (s.ctrl.hc2 & keep2) |
                          (`SBCRA_HC2_POR & ~keep2);
            n.ctrl.gpio = lock0 ? s.ctrl.gpio : `SBCRA_GPIO_POR;
            for (int i = 0; i < `SBCRA_N_WC; i++)
            begin
                n.wc[i] = `SBCRA_WC_CLR;
            end
        end
        // Hardware sets are applied last so that a set beats any clear.
        for (int i = 0; i < `SBCRA_N_WC; i++)
        begin
            n.wc[i] = n.wc[i] | (hw_stat[i] & STAT_MASK[i]);
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Chip select syncs reset high so no false frame start is seen.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s          <= '0;
            s.sy1.cs_n <= 1'b1;
            s.sy2.cs_n <= 1'b1;
            s.dly.cs_n <= 1'b1;
            s.wc[0]    <= `SBCRA_SUP_POR;
        end
        else
        begin
            s <= n;
        end
    end

    assign miso       = s.miso;
    assign miso_oe    = s.oe;
    assign ctrl       = s.ctrl;
    assign soft_reset = s.srst_out;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_mode_soft_reset: assert property (
        (cs_rise && s.rx[`SBCRA_RW_BIT] && (s.cnt == `SBCRA_BITS_SHORT) &&
         (addr == `SBCRA_A_MSC) && (s.rx[15:14] == `SBCRA_MODE_RST))
        |=> s.srst_pend ##1 (s.ctrl.msc == `SBCRA_MSC_POR) ##0 soft_reset)
        else $error("mode reset code did not reset");

    a_restart_keep: assert property (
        (restart && !s.srst_pend)
        |=> (s.ctrl.msc[1:0] == $past(s.ctrl.msc[1:0])) &&
            (s.ctrl.msc[7:2] == 6'h00))
        else $error("restart value wrong");

    a_lock0_survive: assert property (
        (s.srst_pend && lock0) |=> lock0 && $stable(s.ctrl.gpio))
        else $error("first lock lost on soft reset");

    a_lock1_sticky: assert property (
        lock1 |=> lock1 && (s.ctrl.hc2[7:4] == $past(s.ctrl.hc2[7:4])))
        else $error("second lock released");

    a_locked_pump: assert property (
        lock0 |=> (s.ctrl.hc1[2] == $past(s.ctrl.hc1[2])))
        else $error("locked pump enable changed");

    a_unlocked_reset: assert property (
        (s.srst_pend && !lock0) |=> (s.ctrl.gpio == `SBCRA_GPIO_POR))
        else $error("unlocked bits not reset");

    a_reserved_zero: assert property (
        !s.ctrl.msc[5])
        else $error("reserved bit set");

    a_read_no_change: assert property (
        (cs_rise && !s.rx[`SBCRA_RW_BIT] && !s.srst_pend && !restart &&
         !hw_mode_load) |=> (s.ctrl == $past(s.ctrl)))
        else $error("read frame changed a register");

    a_gpio_write: assert property (
        (cs_rise && s.rx[`SBCRA_RW_BIT] && (s.cnt == `SBCRA_BITS_SHORT) &&
         (addr == `SBCRA_A_GPIO) && !lock0 && !s.srst_pend)
        |=> (s.ctrl.gpio == $past(s.rx[15:8])))
        else $error("write frame not applied");

    a_flag_set_wins: assert property (
        1'b1 |=> ((s.wc[1] & $past(hw_stat[1]) & STAT_MASK[1]) ==
                  ($past(hw_stat[1]) & STAT_MASK[1])))
        else $error("status set lost");

    a_miso_edges: assert property (
        (!sck_fall && !cs_fall && !cs_rise) |=> $stable(miso))
        else $error("miso moved off a clock edge");

endmodule : sbcra_top

// ==== hdl/sbcra_consts.svh ====
`ifndef SBCRA_CONSTS_SVH
`define SBCRA_CONSTS_SVH
// Register addresses on the 7-bit word address field.
`define SBCRA_A_MSC      7'h01
`define SBCRA_A_HC1      7'h0E
`define SBCRA_A_HC2      7'h0F
`define SBCRA_A_GPIO     7'h17
`define SBCRA_A_STAT     7'h40
`define SBCRA_A_STEND    7'h4D
`define SBCRA_N_STAT     13
`define SBCRA_N_WC       8
`define SBCRA_IDX_FAULT  4'h2
// Frame layout and bit counts.
`define SBCRA_RW_BIT     7
`define SBCRA_CNT_ADDR   6'h07
`define SBCRA_CNT_MAX    6'h3F
`define SBCRA_BITS_SHORT 6'h10
`define SBCRA_BITS_LONG  6'h20
// Mode field code that executes a soft reset.
`define SBCRA_MODE_RST   2'h3
// Field masks.
`define SBCRA_MSC_RSV    8'h20
`define SBCRA_MSC_KEEP   8'h03
`define SBCRA_HC1_LK0    8'h01
`define SBCRA_HC1_LKD    8'h04
`define SBCRA_HC2_LK1    8'h01
`define SBCRA_HC2_LKD    8'hF0
`define SBCRA_GPIO_LKD   8'hFF
// Power-on and soft reset values.
`define SBCRA_MSC_POR    8'h00
`define SBCRA_HC1_POR    8'h00
`define SBCRA_HC2_POR    8'h00
`define SBCRA_GPIO_POR   8'h00
`define SBCRA_SUP_POR    8'h80
`define SBCRA_WC_CLR     8'h00
// Implemented bits of the status registers, index 12 first.
`define SBCRA_STAT_MASK  {8'hF0, 8'hFF, 8'h3F, 8'h4F, 8'hC1, 8'h40, 8'h40, \
                          8'h10, 8'h31, 8'h1F, 8'hCF, 8'h0F, 8'h9D}
`endif

// ==== hdl/sbcra_pkg.sv ====
package sbcra_pkg;
`include "sbcra_consts.svh"

    typedef logic [7:0] sbcra_byte_t;

    typedef logic [`SBCRA_N_STAT-1:0][7:0] sbcra_stat_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
    } sbcra_spi_t;

    typedef struct packed {
        sbcra_byte_t msc;
        sbcra_byte_t hc1;
        sbcra_byte_t hc2;
        sbcra_byte_t gpio;
    } sbcra_ctrl_t;

    typedef struct packed {
        sbcra_spi_t                     sy1;
        sbcra_spi_t                     sy2;
        sbcra_spi_t                     dly;
        logic [5:0]                     cnt;
        logic [31:0]                    rx;
        logic [15:0]                    sh;
        logic                           miso;
        logic                           oe;
        sbcra_ctrl_t                    ctrl;
        logic [`SBCRA_N_WC-1:0][7:0]    wc;
        logic                           srst_pend;
        logic                           srst_out;
    } sbcra_state_t;

endpackage : sbcra_pkg

// ==== tb/sbcra_master_model.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Serial master model on the far side of the register bank
// ****************************************************************
module sbcra_master_model (
    input  wire logic             clk,
    input  wire logic             miso,
    output sbcra_pkg::sbcra_spi_t spi_out
);
    import sbcra_pkg::*;

    // Idle: clock low and stopped, select high, data line low.
    initial
    begin
        spi_out = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    end

    // One frame, LSB first, eight cycles a bit; the clock runs only inside it.
    // Returned bits are taken just before the falling edge, where they have settled.
    task automatic xfer(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        @(negedge clk);
        spi_out.cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 0; i < nbits; i++)
        begin
            spi_out.mosi = tx[i];
            repeat (4) @(negedge clk);
            spi_out.sck = 1'b1;
            repeat (4) @(negedge clk);
            rx[i] = miso;
            spi_out.sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        spi_out.cs_n = 1'b1;
        // Nobody drives the data line now, so it must not keep the last bit.
        spi_out.mosi = ~spi_out.mosi;
        repeat (10) @(negedge clk);
    endtask : xfer
endmodule : sbcra_master_model

// ==== tb/test_sbcra_top.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench for the serial register bank
// ****************************************************************
module test_sbcra_top;
    import sbcra_pkg::*;

    logic        clk;
    logic        rst;
    sbcra_spi_t  spi_in;
    logic        miso;
    logic        miso_oe;
    sbcra_stat_t hw_stat;
    logic        hw_mode_load;
    logic [1:0]  hw_mode;
    logic        restart;
    sbcra_ctrl_t ctrl;
    logic        soft_reset;
    logic [31:0] rx;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_srst = 0;
    logic        oe_seen = 1'b0;

    sbcra_top #(.CNT_W(6)) u_sbcra_top (
        .clk          (clk),
        .rst          (rst),
        .spi_in       (spi_in),
        .miso         (miso),
        .miso_oe      (miso_oe),
        .hw_stat      (hw_stat),
        .hw_mode_load (hw_mode_load),
        .hw_mode      (hw_mode),
        .restart      (restart),
        .ctrl         (ctrl),
        .soft_reset   (soft_reset)
    );

    sbcra_master_model u_sbcra_master_model (
        .clk     (clk),
        .miso    (miso),
        .spi_out (spi_in)
    );

    // Free-running 100 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Count soft reset pulses; a pulse longer than one cycle counts once per cycle.
    // Sampled on the falling edge so the launching edge cannot race the count.
    always @(negedge clk)
        if (soft_reset === 1'b1)
            n_srst++;

    // Remember whether the device drove its data line since the last clear.
    always @(negedge clk)
        if (miso_oe === 1'b1)
            oe_seen = 1'b1;

    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : check

    // Whole control word, msc in the top byte.
    task automatic chk_ctrl(input logic [31:0] exp);
        for (int i = 0; i < 4; i++)
            check(ctrl[i*8+:8], exp[i*8+:8]);
    endtask : chk_ctrl

    task automatic do_reset();
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
    endtask : do_reset

    task automatic fr(input int n, input logic [31:0] tx);
        u_sbcra_master_model.xfer(n, tx, rx);
    endtask : fr

    // The unused upper half of the command is zero and never goes out.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        fr(16, {16'h0000, d, 1'b1, a});
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        fr(16, {16'h0000, 8'h00, 1'b0, a});
        check(rx[15:8], exp);
    endtask : rd

    task automatic srst();
        int n0;
        n0 = n_srst;
        wr(7'h01, 8'hC0);
        check(8'(n_srst - n0), 8'h01);
    endtask : srst

    task automatic t_reset();
        chk_ctrl(32'h00000000);
        check({7'h00, miso_oe}, 8'h00);
        oe_seen = 1'b0;
        rd(7'h40, 8'h80);
        check({7'h00, oe_seen}, 8'h01);
        check({7'h00, miso_oe}, 8'h00);
        rd(7'h41, 8'h00);
    endtask : t_reset

    task automatic t_rw();
        wr(7'h01, 8'h7F);
        rd(7'h01, 8'h5F);
        chk_ctrl(32'h5F000000);
        wr(7'h17, 8'hA5);
        wr(7'h05, 8'hFF);
        fr(24, {8'h00, 8'hFF, 8'h00, 1'b1, 7'h17});
        chk_ctrl(32'h5F0000A5);
        rd(7'h17, 8'hA5);
    endtask : t_rw

    task automatic t_long();
        fr(32, {8'h00, 8'h50, 8'h04, 1'b1, 7'h0E});
        chk_ctrl(32'h5F0450A5);
        hw_stat[12] = 8'hFF;
        fr(32, {8'h00, 8'h00, 8'h00, 1'b0, 7'h4C});
        check(rx[15:8], 8'hF0);
        check(rx[23:16], 8'h5F);
    endtask : t_long

    task automatic t_readonly();
        hw_stat[8] = 8'hFF;
        rd(7'h48, 8'hC1);
        wr(7'h48, 8'h00);
        rd(7'h48, 8'hC1);
    endtask : t_readonly

    task automatic t_status();
        hw_stat[1] = 8'hFF;
        repeat (2) @(negedge clk);
        hw_stat[1] = 8'h00;
        rd(7'h41, 8'h0F);
        rd(7'h41, 8'h0F);
        wr(7'h41, 8'h00);
        rd(7'h41, 8'h00);
        hw_stat[1] = 8'h01;
        wr(7'h41, 8'h00);
        rd(7'h41, 8'h01);
        hw_stat[1] = 8'h00;
        wr(7'h41, 8'h00);
        hw_stat[2] = 8'hFF;
        @(negedge clk);
        hw_stat[2] = 8'h00;
        rd(7'h41, 8'h00);
        check(rx[7:0], 8'hCF);
        wr(7'h42, 8'h00);
    endtask : t_status

    // Mode field loaded by the chip, then a restart keeping only bits 1:0.
    task automatic t_hw();
        hw_mode = 2'h2;
        hw_mode_load = 1'b1;
        @(negedge clk);
        hw_mode_load = 1'b0;
        repeat (3) @(negedge clk);
        chk_ctrl(32'h9F0450A5);
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        repeat (3) @(negedge clk);
        chk_ctrl(32'h030450A5);
    endtask : t_hw

    task automatic t_lock0();
        srst();
        chk_ctrl(32'h00000000);
        wr(7'h17, 8'h3C);
        wr(7'h0E, 8'h05);
        wr(7'h17, 8'h00);
        check(ctrl.gpio, 8'h3C);
        wr(7'h0E, 8'h01);
        check(ctrl.hc1, 8'h05);
        srst();
        chk_ctrl(32'h0005003C);
        wr(7'h0E, 8'h00);
        check({7'h00, ctrl.hc1[0]}, 8'h00);
        wr(7'h17, 8'h11);
        check(ctrl.gpio, 8'h11);
        wr(7'h0E, 8'h00);
        check(ctrl.hc1, 8'h00);
    endtask : t_lock0

    task automatic t_lock1();
        wr(7'h0F, 8'hA0);
        wr(7'h0F, 8'hA1);
        wr(7'h0F, 8'h00);
        check(ctrl.hc2, 8'hA1);
        srst();
        check(ctrl.hc2, 8'hA1);
        check(ctrl.gpio, 8'h00);
        do_reset();
        chk_ctrl(32'h00000000);
    endtask : t_lock1

    // Main sequence.
    initial
    begin
        hw_stat = '0;
        hw_mode_load = 1'b0;
        hw_mode = 2'h0;
        restart = 1'b0;
        do_reset();
        t_reset();
        t_rw();
        t_long();
        t_readonly();
        t_status();
        t_hw();
        t_lock0();
        t_lock1();
        complete_run();
    end

    // A hang anywhere ends the run as a failure.
    initial
    begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule : test_sbcra_top
